// [core/tohp_pkg.sv]
// Constants shared by the transmit overhead insert port and its testbench.
// Assumes a 200 MHz core clock and a free running 8 MHz link clock.
package tohp_pkg;
   localparam int CLK_PERIOD_NS = 5;
   localparam int LINK_PERIOD_NS = 125;
   localparam int FRAME_NS = 125000;
   // Port clock is the link clock divided by two
   localparam int PORT_PERIOD_NS = 2 * LINK_PERIOD_NS;
   localparam int SLOTS_PER_FRAME = FRAME_NS / PORT_PERIOD_NS;
   localparam int SLOT_W = 9;
   localparam int IDX_W = 5;
   localparam int SYNC_STAGES = 2;
   // First STS-1 overhead: 9 rows of 3 bytes, row major
   localparam logic [IDX_W-1:0] TOH_BYTES = 5'h1B;
   localparam logic [SLOT_W-1:0] TOH_SLOTS = 9'h0D8;
   localparam logic [IDX_W-1:0] ROW0_BYTES = 5'h03;
   // Line channel bytes D4..D12 sit at rows 5 to 7
   localparam logic [IDX_W-1:0] DCC_FIRST = 5'h0F;
   localparam logic [IDX_W-1:0] DCC_LAST = 5'h17;
   localparam logic [2:0] LAST_BIT = 3'h7;
   // Core clocks the link side stays in reset after rst_i drops
   localparam logic [7:0] RST_HOLD = 8'h80;
endpackage : tohp_pkg

// [core/tohp_sync.sv]
// Two flip-flop level synchroniser, one per bit.
// Assumes each bit is a level that stays put for several destination clocks.
`timescale 1ns/10ps
module tohp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } tohp_sync_t;

   tohp_sync_t sync_reg;
   tohp_sync_t sync_next;

   // No reset: a reset here would put the reset itself through this path
   always_comb begin
      sync_next = sync_reg;
      sync_next.s1 = d_i;
      sync_next.s2 = sync_reg.s1;
   end

   always_ff @(posedge clk_i) begin
      sync_reg <= sync_next;
   end

   assign q_o = sync_reg.s2;
endmodule : tohp_sync

// [core/tohp_port.sv]
// Transmit overhead serial insert port: port clock, frame and ready strobes,
// bit sampling on the link side, byte hand-off and merge on the core side.
// Assumes link_clk_i runs free, also during reset, and the user logic is
// clocked by overhead_port_clock_o.
//
// How it works
// - Frame pulse is one port period, ending one period before bit zero.
// - Overhead serial input is captured on the port clock falling edge.
// - Framing-row serial input ignored unless ready strobe and insert enable both high.
// - Insert enable low keeps port disabled for the strict framing-row bytes.
// - Other bytes outside D4 to D12 sample on ready and enable, or enable and software both low.
// - Line channel bits fill D4 to D12, with their own ready strobe.
// - Line channel input is captured on the shared port clock falling edge.
// - One of the two ready strobes stays high throughout every slot that accepts bits.
// - Only the first STS-1 overhead bytes are offered for insertion.
`timescale 1ns/10ps
module tohp_port #(
   parameter int SLOTS = tohp_pkg::SLOTS_PER_FRAME
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic link_clk_i,
   input wire logic sw_insert_en_i,
   input wire logic overhead_serial_i,
   input wire logic overhead_insert_enable_i,
   input wire logic line_channel_serial_i,
   input wire logic [7:0] internal_byte_i,
   output logic overhead_port_clock_o,
   output logic overhead_frame_pulse_o,
   output logic overhead_ready_strobe_o,
   output logic line_channel_ready_o,
   output logic [tohp_pkg::IDX_W-1:0] internal_index_o,
   output logic [7:0] ovh_byte_o,
   output logic [7:0] ovh_mask_o,
   output logic [tohp_pkg::IDX_W-1:0] ovh_index_o,
   output logic ovh_valid_o
);
   localparam logic [tohp_pkg::SLOT_W-1:0] LAST_SLOT = tohp_pkg::SLOT_W'(SLOTS - 1);
   localparam logic [tohp_pkg::SLOT_W-1:0] FRAME_SLOT = tohp_pkg::SLOT_W'(SLOTS - 2);

   typedef struct packed {
      logic phase;
      logic [tohp_pkg::SLOT_W-1:0] slot;
      logic frame;
      logic ready;
      logic lready;
      logic take;
      logic shift;
      logic [tohp_pkg::SLOT_W-1:0] tslot;
      logic trdy;
      logic tlrdy;
      logic [7:0] sh;
      logic [7:0] msk;
      logic [7:0] xbyte;
      logic [7:0] xmask;
      logic [tohp_pkg::IDX_W-1:0] xidx;
      logic xtgl;
   } tohp_link_t;

   typedef struct packed {
      logic tgl_prev;
      logic pend;
      logic [tohp_pkg::IDX_W-1:0] idx;
      logic [7:0] ext;
      logic [7:0] msk;
      logic [7:0] obyte;
      logic [7:0] omsk;
      logic [tohp_pkg::IDX_W-1:0] oidx;
      logic ovalid;
      logic [7:0] rstc;
      logic lrun;
   } tohp_core_t;

   tohp_link_t lr_reg;
   tohp_link_t lr_next;
   tohp_core_t cr_reg;
   tohp_core_t cr_next;
   logic lrst;
   logic [3:0] pins_s;
   logic sw_s;
   logic ins_s;
   logic toh_s;
   logic ldcc_s;
   logic tgl_s;
   logic [2:0] pos;
   logic [tohp_pkg::IDX_W-1:0] tidx;
   logic tbit;
   logic tk;

   function automatic logic [tohp_pkg::IDX_W-1:0] slot_idx(
      input logic [tohp_pkg::SLOT_W-1:0] s);
      slot_idx = s[tohp_pkg::IDX_W+2:3];
   endfunction : slot_idx

   function automatic logic is_toh(input logic [tohp_pkg::SLOT_W-1:0] s);
      is_toh = s < tohp_pkg::TOH_SLOTS;
   endfunction : is_toh

   function automatic logic is_dcc(input logic [tohp_pkg::IDX_W-1:0] i);
      is_dcc = (i >= tohp_pkg::DCC_FIRST) && (i <= tohp_pkg::DCC_LAST);
   endfunction : is_dcc

   // Stretched reset from a register, so no glitch enters the crossing
   tohp_sync #(.WIDTH(1)) u_sync_rst (
      .clk_i(link_clk_i),
      .d_i(!cr_reg.lrun),
      .q_o(lrst)
   );

   // Pins come from logic clocked by our own port clock, but cross anyway
   tohp_sync #(.WIDTH(4)) u_sync_pins (
      .clk_i(link_clk_i),
      .d_i({sw_insert_en_i, overhead_insert_enable_i, overhead_serial_i,
            line_channel_serial_i}),
      .q_o(pins_s)
   );

   tohp_sync #(.WIDTH(1)) u_sync_tgl (
      .clk_i(clk_i),
      .d_i(lr_reg.xtgl),
      .q_o(tgl_s)
   );

   assign sw_s = pins_s[3];
   assign ins_s = pins_s[2];
   assign toh_s = pins_s[1];
   assign ldcc_s = pins_s[0];

   // Link side: one port period is two link clocks
   always_comb begin
      lr_next = lr_reg;
      // Falling-edge sample reaches the second sync stage one link clock later
      lr_next.shift = lr_reg.take;
      pos = lr_reg.tslot[2:0];
      tidx = slot_idx(lr_reg.tslot);
      tbit = toh_s;
      tk = 1'b0;
      if (lr_reg.phase) begin
         // Falling port clock edge: first sync stage captures the pins here
         lr_next.phase = 1'b0;
         lr_next.take = 1'b1;
         lr_next.tslot = lr_reg.slot;
         lr_next.trdy = lr_reg.ready;
         lr_next.tlrdy = lr_reg.lready;
         lr_next.slot = (lr_reg.slot == LAST_SLOT) ? '0 : lr_reg.slot + 9'h001;
         lr_next.frame = lr_next.slot == FRAME_SLOT;
         // Ready held over each run of accepting slots outside D4 to D12
         lr_next.ready = is_toh(lr_next.slot) && !is_dcc(slot_idx(lr_next.slot));
         lr_next.lready = is_toh(lr_next.slot) && is_dcc(slot_idx(lr_next.slot));
      end else begin
         lr_next.phase = 1'b1;
         lr_next.take = 1'b0;
      end
      if (lr_reg.shift && is_toh(lr_reg.tslot)) begin
         if (lr_reg.tlrdy) begin
            tbit = ldcc_s;
            tk = 1'b1;
         end else if (tidx < tohp_pkg::ROW0_BYTES) begin
            tk = lr_reg.trdy && ins_s;
         end else begin
            tk = (lr_reg.trdy && ins_s) || (!ins_s && !sw_s);
         end
         lr_next.sh[3'h7 - pos] = tbit;
         lr_next.msk[3'h7 - pos] = tk;
         if (pos == tohp_pkg::LAST_BIT) begin
            // Words stay put for 16 link clocks, far longer than the crossing
            lr_next.xbyte = lr_next.sh;
            lr_next.xmask = lr_next.msk;
            lr_next.xidx = tidx;
            lr_next.xtgl = ~lr_reg.xtgl;
            lr_next.sh = '0;
            lr_next.msk = '0;
         end
      end
   end

   always_ff @(posedge link_clk_i) begin
      if (lrst) begin
         lr_reg <= '0;
      end else begin
         lr_reg <= lr_next;
      end
   end

   // Core side: toggle handshake, then merge with the internal byte
   always_comb begin
      cr_next = cr_reg;
      cr_next.pend = 1'b0;
      cr_next.ovalid = 1'b0;
      // A short rst_i could fall between two link clocks and be missed there
      if (cr_reg.rstc != tohp_pkg::RST_HOLD) begin
         cr_next.rstc = cr_reg.rstc + 8'h01;
      end
      cr_next.lrun = cr_reg.rstc == tohp_pkg::RST_HOLD;
      if (tgl_s != cr_reg.tgl_prev) begin
         cr_next.tgl_prev = tgl_s;
         cr_next.pend = 1'b1;
         cr_next.idx = lr_reg.xidx;
         cr_next.ext = lr_reg.xbyte;
         cr_next.msk = lr_reg.xmask;
      end
      if (cr_reg.pend) begin
         cr_next.obyte = (cr_reg.ext & cr_reg.msk) | (internal_byte_i & ~cr_reg.msk);
         cr_next.omsk = cr_reg.msk;
         cr_next.oidx = cr_reg.idx;
         cr_next.ovalid = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cr_reg <= '0;
      end else begin
         cr_reg <= cr_next;
      end
   end

   assign overhead_port_clock_o = lr_reg.phase;
   assign overhead_frame_pulse_o = lr_reg.frame;
   assign overhead_ready_strobe_o = lr_reg.ready;
   assign line_channel_ready_o = lr_reg.lready;
   assign internal_index_o = cr_reg.idx;
   assign ovh_byte_o = cr_reg.obyte;
   assign ovh_mask_o = cr_reg.omsk;
   assign ovh_index_o = cr_reg.oidx;
   assign ovh_valid_o = cr_reg.ovalid;

   sequence frame_high_one_period;
      lr_reg.frame [*2] ##1 !lr_reg.frame;
   endsequence

   sequence first_bit_slot;
      ##2 (lr_reg.slot == '0) && lr_reg.ready;
   endsequence

   AST_FRAME_ONE_PERIOD: assert property (@(posedge link_clk_i) disable iff (lrst)
      $rose(lr_reg.frame) |-> frame_high_one_period)
      else $error("frame pulse not one port period");

   AST_FRAME_LEAD: assert property (@(posedge link_clk_i) disable iff (lrst)
      $fell(lr_reg.frame) |-> first_bit_slot)
      else $error("first bit slot not one period after frame pulse");

   AST_SAMPLE_FALL: assert property (@(posedge link_clk_i) disable iff (lrst)
      lr_reg.take |-> !lr_reg.phase && $past(lr_reg.phase))
      else $error("sample not tied to falling port clock");

   AST_IGNORE: assert property (@(posedge link_clk_i) disable iff (lrst)
      (lr_reg.shift && is_toh(lr_reg.tslot) && !lr_reg.tlrdy && tidx < tohp_pkg::ROW0_BYTES
       && !(lr_reg.trdy && ins_s) && pos != tohp_pkg::LAST_BIT) |=> !lr_reg.msk[3'h7 - $past(pos)])
      else $error("bit taken without ready and enable");

   AST_DISABLED: assert property (@(posedge link_clk_i) disable iff (lrst)
      (lr_reg.shift && !lr_reg.tlrdy && !ins_s && sw_s && pos != tohp_pkg::LAST_BIT)
      |=> !lr_reg.msk[3'h7 - $past(pos)])
      else $error("bit taken while insert disabled");

   AST_SW_LOW_TAKE: assert property (@(posedge link_clk_i) disable iff (lrst)
      (lr_reg.shift && is_toh(lr_reg.tslot) && tidx >= tohp_pkg::ROW0_BYTES && !ins_s && !sw_s
       && pos != tohp_pkg::LAST_BIT) |=> lr_reg.msk[3'h7 - $past(pos)])
      else $error("bit not taken with enable and software both low");

   AST_READY_HOLD: assert property (@(posedge link_clk_i) disable iff (lrst)
      $rose(lr_reg.ready) |-> lr_reg.ready [*8])
      else $error("ready strobe dropped early");

   AST_DCC_WINDOW: assert property (@(posedge link_clk_i) disable iff (lrst)
      lr_reg.lready |-> is_dcc(slot_idx(lr_reg.slot)) && is_toh(lr_reg.slot) && !lr_reg.ready)
      else $error("line channel ready outside D4 to D12");

   AST_MERGE: assert property (@(posedge clk_i) disable iff (rst_i)
      ovh_valid_o |-> ovh_byte_o == (($past(cr_reg.ext) & $past(cr_reg.msk))
                                     | ($past(internal_byte_i) & ~$past(cr_reg.msk))))
      else $error("merged byte wrong");

   AST_FIRST_STS1: assert property (@(posedge clk_i) disable iff (rst_i)
      ovh_valid_o |-> ovh_index_o < tohp_pkg::TOH_BYTES)
      else $error("byte index beyond first STS-1");
endmodule : tohp_port

// [test/tohp_user_model.sv]
// Far side model: user overhead logic plus line channel controller.
// Assumes it is clocked by the port clock and sees the device strobes.
`timescale 1ns/10ps
module tohp_user_model (
   input wire logic port_clk_i,
   input wire logic frame_i,
   input wire logic ready_i,
   input wire logic line_ready_i,
   input wire logic ins_follow_i,
   output logic serial_o,
   output logic ins_o,
   output logic line_o
);
   int k = 0;
   logic [7:0] ovh;
   logic [7:0] dcc;
   initial begin
      serial_o = 1'b0;
      ins_o = 1'b0;
      line_o = 1'b0;
   end
   always @(posedge port_clk_i) begin
      // Two slots from pulse to bit zero
      k = (frame_i === 1'b1) ? -2 : k + 1;
      ovh = 8'hA0 | 8'(k / 8);
      dcc = 8'h3C ^ 8'(k / 8);
      ins_o <= ins_follow_i & ready_i;
      // Outside the bit slots the line toggles so stale data never matches
      serial_o <= (k >= 0 && k < 216) ? ovh[7 - k % 8] : ~serial_o;
      line_o <= (line_ready_i === 1'b1) ? dcc[7 - k % 8] : ~line_o;
   end
endmodule : tohp_user_model

// [test/testbench.sv]
// Bench for the overhead insert port: frame timing, strobes, byte merge.
// Assumes tohp_user_model drives the far side of the port.
`timescale 1ns/10ps
module testbench;
   localparam int SLOTS = 230;
   logic clk_i = 1'b0;
   logic link_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic sw_insert_en_i = 1'b1;
   logic ins_follow = 1'b1;
   logic overhead_serial_i, overhead_insert_enable_i, line_channel_serial_i;
   logic [7:0] internal_byte_i;
   logic overhead_port_clock_o, overhead_frame_pulse_o, overhead_ready_strobe_o;
   logic line_channel_ready_o, ovh_valid_o;
   logic [tohp_pkg::IDX_W-1:0] internal_index_o, ovh_index_o;
   logic [7:0] ovh_byte_o, ovh_mask_o;
   int error_cnt = 0;
   int n_compared = 0;
   // Internal value source answers the index combinationally
   assign internal_byte_i = 8'hC3 ^ {3'h0, internal_index_o};
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      #17.3;
      forever #62.5 link_clk_i = ~link_clk_i;
   end
   tohp_port #(.SLOTS(SLOTS)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
      .sw_insert_en_i(sw_insert_en_i), .overhead_serial_i(overhead_serial_i),
      .overhead_insert_enable_i(overhead_insert_enable_i),
      .line_channel_serial_i(line_channel_serial_i), .internal_byte_i(internal_byte_i),
      .overhead_port_clock_o(overhead_port_clock_o),
      .overhead_frame_pulse_o(overhead_frame_pulse_o),
      .overhead_ready_strobe_o(overhead_ready_strobe_o),
      .line_channel_ready_o(line_channel_ready_o), .internal_index_o(internal_index_o),
      .ovh_byte_o(ovh_byte_o), .ovh_mask_o(ovh_mask_o), .ovh_index_o(ovh_index_o),
      .ovh_valid_o(ovh_valid_o));
   tohp_user_model u_user (.port_clk_i(overhead_port_clock_o),
      .frame_i(overhead_frame_pulse_o), .ready_i(overhead_ready_strobe_o),
      .line_ready_i(line_channel_ready_o), .ins_follow_i(ins_follow),
      .serial_o(overhead_serial_i), .ins_o(overhead_insert_enable_i),
      .line_o(line_channel_serial_i));
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict
   task automatic wait_valid();
      int t;
      t = 0;
      do begin
         @(negedge clk_i);
         t++;
      end while (ovh_valid_o !== 1'b1 && t < 30000);
      check("valid", 8'(ovh_valid_o), 8'h01);
   endtask : wait_valid
   task automatic frame_timing();
      int hi;
      int n;
      int rdy;
      int lrdy;
      hi = 0;
      n = 0;
      rdy = 0;
      lrdy = 0;
      while (overhead_frame_pulse_o !== 1'b1 && n < 2000) begin
         @(negedge link_clk_i);
         n++;
      end
      while (overhead_frame_pulse_o === 1'b1 && hi < 10) begin
         hi++;
         @(negedge link_clk_i);
      end
      check("frame_width", 8'(hi), 8'h02);
      n = 0;
      do begin
         @(posedge overhead_port_clock_o);
         n++;
         rdy += int'(overhead_ready_strobe_o === 1'b1);
         lrdy += int'(line_channel_ready_o === 1'b1);
      end while (overhead_frame_pulse_o !== 1'b1 && n < 1000);
      check("frame_spacing", 8'(n), 8'(SLOTS));
      check("ready_slots", 8'(rdy), 8'h90);
      check("line_ready_slots", 8'(lrdy), 8'h48);
   endtask : frame_timing
   // One frame of bytes under a given insert enable and software setting
   task automatic merge_frame(input logic follow, input logic sw, input logic [7:0] lo_m,
         input logic [7:0] hi_m);
      int i;
      logic [7:0] d;
      logic [7:0] m;
      @(posedge clk_i);
      ins_follow <= follow;
      sw_insert_en_i <= sw;
      i = 0;
      do begin
         wait_valid();
         i++;
      end while (ovh_index_o !== 5'h00 && i < 40);
      for (i = 0; i < 27; i++) begin
         if (i > 0) begin
            wait_valid();
         end
         check("index", 8'(ovh_index_o), 8'(i));
         check("internal_index", 8'(internal_index_o), 8'(i));
         if (i >= 15 && i <= 23) begin
            d = 8'h3C ^ 8'(i);
            m = 8'hFF;
         end else begin
            d = 8'hA0 | 8'(i);
            m = (i < 3) ? lo_m : hi_m;
         end
         check("mask", ovh_mask_o, m);
         check("byte", ovh_byte_o, (d & m) | ((8'hC3 ^ 8'(i)) & ~m));
      end
   endtask : merge_frame
   initial begin
      // Block stretches reset for its link side by itself
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      frame_timing();
      merge_frame(1'b1, 1'b1, 8'hFF, 8'hFF);
      merge_frame(1'b0, 1'b1, 8'h00, 8'h00);
      merge_frame(1'b0, 1'b0, 8'h00, 8'hFF);
      give_verdict();
   end
   initial begin
      repeat (80000) @(posedge clk_i);
      error_cnt++;
      give_verdict();
   end
endmodule : testbench
